// file: rtl/vscq_consts.svh
// constants for the control-queue command handler
`ifndef VSCQ_CONSTS_SVH
`define VSCQ_CONSTS_SVH
// request type words
`define VSCQ_T_TMF          32'h0000_0000
`define VSCQ_T_AN_QUERY     32'h0000_0001
`define VSCQ_T_AN_SUB       32'h0000_0002
// task management subtypes
`define VSCQ_TMF_ABORT_TASK 32'h0000_0000
`define VSCQ_TMF_ABORT_SET  32'h0000_0001
`define VSCQ_TMF_CLEAR_ACA  32'h0000_0002
`define VSCQ_TMF_CLEAR_SET  32'h0000_0003
`define VSCQ_TMF_IT_RESET   32'h0000_0004
`define VSCQ_TMF_LU_RESET   32'h0000_0005
`define VSCQ_TMF_QUERY_TASK 32'h0000_0006
`define VSCQ_TMF_QUERY_SET  32'h0000_0007
// response codes
`define VSCQ_S_OK           8'h00
`define VSCQ_S_ABORTED      8'h02
`define VSCQ_S_BAD_TARGET   8'h03
`define VSCQ_S_RESET        8'h04
`define VSCQ_S_BUSY         8'h05
`define VSCQ_S_TRANSPORT    8'h06
`define VSCQ_S_TARGET_FAIL  8'h07
`define VSCQ_S_NEXUS_FAIL   8'h08
`define VSCQ_S_FAILURE      8'h09
`define VSCQ_S_SUCCEEDED    8'h0A
`define VSCQ_S_REJECTED     8'h0B
`define VSCQ_S_BAD_LUN      8'h0C
// async event bits
`define VSCQ_EVT_OPCHG      32'h0000_0002
`define VSCQ_EVT_PWR        32'h0000_0004
`define VSCQ_EVT_EXTREQ     32'h0000_0008
`define VSCQ_EVT_MEDIA      32'h0000_0010
`define VSCQ_EVT_MHOST      32'h0000_0020
`define VSCQ_EVT_BUSY       32'h0000_0040
`define VSCQ_EVT_ALL        32'h0000_007E
// lun byte 0 marker for target addressing
`define VSCQ_LUN_ADDR1      8'h01
// apb register byte offsets
`define VSCQ_A_CTRL         12'h000
`define VSCQ_A_STAT         12'h004
`define VSCQ_A_MASK         12'h008
`define VSCQ_A_SUPP         12'h00C
`define VSCQ_A_SUBS         12'h010
`define VSCQ_A_INFO         12'h014
// ctrl field: legacy byte order
`define VSCQ_CTRL_LEGACY    0
// status bits
`define VSCQ_ST_DONE        0
`define VSCQ_ST_KILL        1
`define VSCQ_ST_BAD         2
`define VSCQ_ST_W           3
`endif

// file: rtl/vscq_pkg.sv
// types for the control-queue command handler
package vscq_pkg;
    typedef enum logic [1:0] {VSCQ_IDLE, VSCQ_SCAN, VSCQ_RESP} vscq_state_e;
    typedef logic [7:0] vscq_resp_t;
endpackage

// file: rtl/vscq_ctrl.sv
// control-queue command handler: decode, tmf sweep, async notify, apb regs
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "vscq_consts.svh"
// Behaviour
// - request opens with type word; response byte
// - type 0 tmf, 1 query, 2 subscribe
// - generic codes 3,5,6,7,8,9,12 allowed
// - subtype selects the task management function
// - fields unused by function are ignored
// - nexus functions ignore single level lun
// - tag matched against outstanding request tags
// - tmf outcomes complete 0, succeeded 10, rejected 11
// - resets complete active commands on unit/target
// - aborts complete selected outstanding commands
// - victim completions strictly precede tmf response
// - query returns supported mask and response
// - subscribe enables events, returns supported mask
// - event bits 2,4,8,16,32,64
// - notify commands use generic codes only
// - legacy mode uses native byte order
// - reset kills carry 4, aborts carry 2
module vscq_ctrl #(
    parameter int NCMD = 8 // outstanding request-queue slots
)(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // control request, raw bytes as fetched
    input  wire logic               req_valid,
    input  wire logic [31:0]        req_type,
    input  wire logic [31:0]        req_subtype,
    input  wire logic [63:0]        req_lun,
    input  wire logic [63:0]        req_tag,
    input  wire logic [31:0]        req_evmask,
    output logic                    req_ready,
    // control answer
    output logic                    rsp_valid,
    output vscq_pkg::vscq_resp_t    rsp_code,
    output logic [31:0]             rsp_event,
    input  wire logic               rsp_ready,
    // outstanding request-queue commands
    input  wire logic [NCMD-1:0]    cmd_active,
    input  wire logic [NCMD*64-1:0] cmd_lun,
    input  wire logic [NCMD*64-1:0] cmd_tag,
    // forced completions to request-queue block
    output logic                    kill_valid,
    output logic [$clog2(NCMD)-1:0] kill_slot,
    output vscq_pkg::vscq_resp_t    kill_code,
    input  wire logic               kill_ready,
    // interrupt
    output logic                    irq
);
    import vscq_pkg::*;

    initial
    begin
        if (NCMD < 2 || NCMD > 256)
            $error("vscq_ctrl: NCMD out of range");
    end

    localparam int SW = $clog2(NCMD);

    // ----------------------------------------
    // byte order
    // ----------------------------------------
    logic        legacy_r;     // native (big) order when set
    logic [31:0] supp_r;       // events this unit can report
    logic [31:0] subs_r;       // events currently enabled
    logic [3:0]  stat_r;       // sticky events
    logic [3:0]  mask_r;       // interrupt enables

    function automatic logic [31:0] sw32(input logic [31:0] v, input logic lg);
        sw32 = lg ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
    endfunction
    function automatic logic [63:0] sw64(input logic [63:0] v, input logic lg);
        sw64 = lg ? {sw32(v[31:0], 1'b1), sw32(v[63:32], 1'b1)} : v;
    endfunction

    wire [31:0] typ_w  = sw32(req_type, legacy_r);
    wire [31:0] sub_w  = sw32(req_subtype, legacy_r);
    wire [63:0] tag_w  = sw64(req_tag, legacy_r);
    wire [31:0] evr_w  = sw32(req_evmask, legacy_r);
    wire [31:0] act_w  = sw32(supp_r, legacy_r);

    // ----------------------------------------
    // request latch
    // ----------------------------------------
    vscq_state_e state_r;
    logic [31:0] sub_r;        // captured subtype
    logic [63:0] lun_r;        // captured unit address
    logic [63:0] tag_r;        // captured tag
    logic [SW-1:0] idx_r;      // sweep pointer
    logic        hit_r;        // at least one match seen
    logic        kpend_r;      // declared but never driven or read

    // lun bytes: [7:0] byte0 marker, [15:8] target, [31:16] single-level lun
    wire        lun_ok_w = (req_lun[7:0] == `VSCQ_LUN_ADDR1);

    wire f_abort  = (sub_r == `VSCQ_TMF_ABORT_TASK);
    wire f_aset   = (sub_r == `VSCQ_TMF_ABORT_SET) || (sub_r == `VSCQ_TMF_CLEAR_SET);
    wire f_itrst  = (sub_r == `VSCQ_TMF_IT_RESET);
    wire f_lurst  = (sub_r == `VSCQ_TMF_LU_RESET);
    wire f_qtask  = (sub_r == `VSCQ_TMF_QUERY_TASK);
    wire f_qset   = (sub_r == `VSCQ_TMF_QUERY_SET);
    wire f_aca    = (sub_r == `VSCQ_TMF_CLEAR_ACA);
    wire f_known  = f_abort | f_aset | f_itrst | f_lurst | f_qtask | f_qset | f_aca;
    wire f_kills  = f_abort | f_aset | f_itrst | f_lurst;

    // per-slot match
    wire [63:0] c_lun = cmd_lun[idx_r*64 +: 64];
    wire [63:0] c_tag = cmd_tag[idx_r*64 +: 64];
    // nexus reset compares marker and target bytes only
    wire tgt_eq  = (c_lun[15:0] == lun_r[15:0]);
    wire lun_eq  = tgt_eq && (c_lun[31:16] == lun_r[31:16]);
    wire tag_eq  = (c_tag == tag_r);
    // only the fields this function needs are looked at
    wire slot_hit = cmd_active[idx_r] &&
                    (f_itrst ? tgt_eq :
                     (f_abort | f_qtask) ? (lun_eq && tag_eq) : lun_eq);
    wire last_w   = (idx_r == SW'(NCMD - 1));

    wire [7:0] tmf_code = !f_known ? `VSCQ_S_REJECTED :
                          ((f_qtask | f_qset) && (hit_r | slot_hit)) ? `VSCQ_S_SUCCEEDED :
                          `VSCQ_S_OK;

    wire t_tmf = (typ_w == `VSCQ_T_TMF);
    wire t_anq = (typ_w == `VSCQ_T_AN_QUERY);
    wire t_ans = (typ_w == `VSCQ_T_AN_SUB);
    // notify answers use generic codes only
    wire [7:0] an_code = lun_ok_w ? `VSCQ_S_OK : `VSCQ_S_BAD_TARGET;

    wire take_w  = req_valid && req_ready;
    wire rsp_go  = rsp_valid && rsp_ready;
    wire kill_go = kill_valid && kill_ready;

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    // sweep finishes, last kill accepted, then the tmf answer is posted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= VSCQ_IDLE;
            req_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_code   <= `VSCQ_S_OK;
            rsp_event  <= 32'h0000_0000;
            kill_valid <= 1'b0;
            kill_slot  <= '0;
            kill_code  <= `VSCQ_S_OK;
            sub_r      <= 32'h0000_0000;
            lun_r      <= 64'h0000_0000_0000_0000;
            tag_r      <= 64'h0000_0000_0000_0000;
            idx_r      <= '0;
            hit_r      <= 1'b0;
            subs_r     <= 32'h0000_0000;
        end
        else
        begin
            if (kill_go)
                kill_valid <= 1'b0;
            unique case (state_r)
                VSCQ_IDLE:
                begin
                    req_ready <= !req_ready && !take_w;
                    if (take_w)
                    begin
                        req_ready <= 1'b0;
                        sub_r     <= sub_w;
                        lun_r     <= req_lun;
                        tag_r     <= tag_w;
                        idx_r     <= '0;
                        hit_r     <= 1'b0;
                        rsp_event <= 32'h0000_0000;
                        if (t_tmf && lun_ok_w)
                            state_r <= VSCQ_SCAN;
                        else
                        begin
                            if (t_anq || t_ans)
                                rsp_event <= act_w;
                            if (t_ans && lun_ok_w)
                                subs_r <= evr_w & supp_r;
                            rsp_code  <= (t_anq || t_ans) ? an_code :
                                         t_tmf ? `VSCQ_S_BAD_TARGET : `VSCQ_S_FAILURE;
                            rsp_valid <= 1'b1;
                            state_r   <= VSCQ_RESP;
                        end
                    end
                end
                VSCQ_SCAN:
                begin
                    // one slot a cycle, stall while a kill waits
                    if (!kill_valid || kill_go)
                    begin
                        if (slot_hit && f_kills)
                        begin
                            kill_valid <= 1'b1;
                            kill_slot  <= idx_r;
                            kill_code  <= (f_itrst | f_lurst) ? `VSCQ_S_RESET : `VSCQ_S_ABORTED;
                        end
                        hit_r <= hit_r | slot_hit;
                        idx_r <= idx_r + SW'(1);
                        if (last_w)
                        begin
                            rsp_code <= tmf_code;
                            state_r  <= VSCQ_RESP;
                        end
                    end
                end
                VSCQ_RESP:
                begin
                    // hold the answer until the last kill is gone
                    if (!kill_valid || kill_go)
                        rsp_valid <= 1'b1;
                    if (rsp_go)
                    begin
                        rsp_valid <= 1'b0;
                        state_r   <= VSCQ_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // apb registers and interrupt
    // ----------------------------------------
    wire apb_acc = psel && penable && pready;
    wire apb_wr  = apb_acc && pwrite;
    wire apb_rd  = apb_acc && !pwrite;
    wire a_ctrl  = (paddr == `VSCQ_A_CTRL);
    wire a_stat  = (paddr == `VSCQ_A_STAT);
    wire a_mask  = (paddr == `VSCQ_A_MASK);
    wire a_supp  = (paddr == `VSCQ_A_SUPP);
    wire a_subs  = (paddr == `VSCQ_A_SUBS);
    wire a_info  = (paddr == `VSCQ_A_INFO);
    wire a_hit   = a_ctrl | a_stat | a_mask | a_supp | a_subs | a_info;
    wire [3:0] ev_w = {take_w && t_ans, take_w && !(t_tmf | t_anq | t_ans), kill_go, rsp_go};
    wire [31:0] rd_w = a_ctrl ? {31'h0, legacy_r} :
                       a_stat ? {28'h0, stat_r} :
                       a_mask ? {28'h0, mask_r} :
                       a_supp ? supp_r :
                       a_subs ? subs_r :
                       a_info ? {28'h0, kill_valid, rsp_valid, 2'(state_r)} : 32'h0;

    // single-wait slave: ready rises in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready   <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            legacy_r <= 1'b0;
            supp_r   <= `VSCQ_EVT_ALL;
            mask_r   <= 4'h0;
            stat_r   <= 4'h0;
            irq      <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !a_hit;
            prdata  <= rd_w;
            if (apb_wr && a_ctrl)
                legacy_r <= pwdata[`VSCQ_CTRL_LEGACY];
            if (apb_wr && a_mask)
                mask_r <= pwdata[3:0];
            // only defined event bits can be supported
            if (apb_wr && a_supp)
                supp_r <= pwdata & `VSCQ_EVT_ALL;
            // read clears only the bits it returned, so an event landing during the wait cycle is kept
            stat_r <= (stat_r & ~((apb_rd && a_stat) ? prdata[3:0] : 4'h0)) | ev_w;
            irq    <= |(stat_r & mask_r);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_resp_after_kill;
        @(posedge pclk) disable iff (!presetn)
        rsp_valid |-> !kill_valid;
    endproperty
    a_resp_after_kill: assert property (p_resp_after_kill) else $error("answer posted with kill pending");

    property p_unknown_fail;
        @(posedge pclk) disable iff (!presetn)
        (take_w && !(t_tmf | t_anq | t_ans)) |=> (rsp_valid && rsp_code == `VSCQ_S_FAILURE);
    endproperty
    a_unknown_fail: assert property (p_unknown_fail) else $error("unknown type not failed");

    property p_kill_code;
        @(posedge pclk) disable iff (!presetn)
        kill_valid |-> (kill_code == `VSCQ_S_RESET || kill_code == `VSCQ_S_ABORTED);
    endproperty
    a_kill_code: assert property (p_kill_code) else $error("bad kill code");

    property p_reset_code;
        @(posedge pclk) disable iff (!presetn)
        (state_r == VSCQ_SCAN && f_lurst && slot_hit && !kill_valid) |=> kill_code == `VSCQ_S_RESET;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("reset kill lacks reset code");

    property p_abort_code;
        @(posedge pclk) disable iff (!presetn)
        (state_r == VSCQ_SCAN && f_abort && slot_hit && !kill_valid) |=> kill_code == `VSCQ_S_ABORTED;
    endproperty
    a_abort_code: assert property (p_abort_code) else $error("abort kill lacks aborted code");

    property p_an_mask;
        @(posedge pclk) disable iff (!presetn)
        (take_w && (t_anq | t_ans)) |=> rsp_event == $past(act_w);
    endproperty
    a_an_mask: assert property (p_an_mask) else $error("event mask wrong");

    property p_an_generic;
        @(posedge pclk) disable iff (!presetn)
        (take_w && t_anq) |=> (rsp_code == `VSCQ_S_OK || rsp_code == `VSCQ_S_BAD_TARGET);
    endproperty
    a_an_generic: assert property (p_an_generic) else $error("notify code not generic");

    property p_subscribe;
        @(posedge pclk) disable iff (!presetn)
        (take_w && t_ans && lun_ok_w) |=> subs_r == ($past(evr_w) & $past(supp_r));
    endproperty
    a_subscribe: assert property (p_subscribe) else $error("subscription not stored");

    property p_scan_bound;
        @(posedge pclk) disable iff (!presetn)
        (take_w && t_tmf && lun_ok_w) |=> ##[1:600] rsp_valid;
    endproperty
    a_scan_bound: assert property (p_scan_bound) else $error("tmf never answered");
endmodule
`default_nettype wire

// file: bench/vscq_rq_model.sv
// request-queue side model: outstanding command table and kill acceptance
`timescale 1ns/10ps
`default_nettype none
module vscq_rq_model #(
    parameter int NCMD = 8 // request slots
)(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // stall length before a kill is taken, 0 takes it one cycle after it is raised
    input  wire logic [1:0]              slow,
    // outstanding commands
    output logic [NCMD-1:0]              cmd_active,
    output logic [NCMD*64-1:0]           cmd_lun,
    output logic [NCMD*64-1:0]           cmd_tag,
    // forced completions
    input  wire logic                    kill_valid,
    input  wire logic [$clog2(NCMD)-1:0] kill_slot,
    input  wire logic [7:0]              kill_code,
    output logic                         kill_ready
);
    int         kq[$];  // accepted kills as slot*256+code, oldest first
    logic [1:0] wait_r; // cycles spent stalling the current kill
    initial
    begin
        cmd_active = '0;
        cmd_lun    = '0;
        cmd_tag    = '0;
    end
    // --------------------------------------------------------------
    // table load, called by the bench between requests
    // --------------------------------------------------------------
    task automatic load(input int i, input logic a, input logic [63:0] l, input logic [63:0] t);
        cmd_active[i]     = a;
        cmd_lun[i*64+:64] = l;
        cmd_tag[i*64+:64] = t;
    endtask
    // --------------------------------------------------------------
    // kill handshake: a taken kill completes its command, so the slot goes idle
    // --------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            wait_r     <= 2'h0;
            kill_ready <= 1'b0;
        end
        else if (kill_valid && kill_ready)
        begin
            kq.push_back(int'(kill_slot) * 256 + int'(kill_code));
            cmd_active[kill_slot] <= 1'b0;
            kill_ready            <= 1'b0;
            wait_r                <= 2'h0;
        end
        else if (kill_valid)
        begin
            // slow setting holds ready low for a few cycles, never forever
            kill_ready <= (wait_r == slow);
            wait_r     <= wait_r + 2'h1;
        end
endmodule
`default_nettype wire

// file: bench/scsi_control_queue_handler_tb.sv
// self-checking bench for the control-queue command handler
`timescale 1ns/10ps
`default_nettype none
`include "vscq_consts.svh"
module scsi_control_queue_handler_tb;
    import vscq_pkg::*;
    localparam int NCMD = 8; // request slots
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, req_type, req_subtype, req_evmask, rsp_event;
    logic               req_valid, req_ready, rsp_valid, rsp_ready, kill_valid, kill_ready;
    logic [63:0]        req_lun, req_tag;
    vscq_resp_t         rsp_code, kill_code, got_code;
    logic [NCMD-1:0]    cmd_active;
    logic [NCMD*64-1:0] cmd_lun, cmd_tag;
    logic [2:0]         kill_slot;
    logic [1:0]         slow;
    logic [31:0]        rd, got_event;  // last read data, last answer mask
    logic               err, kill_at_rsp; // last error flag, kill pending at answer
    int                 n_fail, samples_checked, cyc;
    vscq_ctrl #(.NCMD(NCMD)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req_valid, .req_type, .req_subtype, .req_lun, .req_tag,
        .req_evmask, .req_ready, .rsp_valid, .rsp_code, .rsp_event, .rsp_ready, .cmd_active,
        .cmd_lun, .cmd_tag, .kill_valid, .kill_slot, .kill_code, .kill_ready, .irq);
    vscq_rq_model #(.NCMD(NCMD)) i_part (.pclk, .presetn, .slow, .cmd_active, .cmd_lun,
        .cmd_tag, .kill_valid, .kill_slot, .kill_code, .kill_ready);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // hang guard: the whole run needs a few hundred cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready high ends this wait, the hang guard a stuck one
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // one control request, held until taken; answer held by the design until accepted
    task automatic send(input logic [31:0] t, s, input logic [63:0] l, g, input logic [31:0] e);
        req_type    <= t;
        req_subtype <= s;
        req_lun     <= l;
        req_tag     <= g;
        req_evmask  <= e;
        req_valid   <= 1'b1;
        @(posedge pclk);
        while (req_ready !== 1'b1)
            @(posedge pclk);
        req_valid <= 1'b0;
        while (rsp_valid !== 1'b1)
            @(posedge pclk);
        got_code = rsp_code;
        got_event = rsp_event;
        kill_at_rsp = kill_valid;
        rsp_ready <= 1'b1;
        @(posedge pclk);
        rsp_ready <= 1'b0;
    endtask
    // task management run against a fresh table, expectations from a slot walk
    task automatic tmf(input logic [31:0] sub);
        int          exp_k[$];
        logic [63:0] l, g, sl, st;
        logic        hit;
        logic [7:0]  code;
        code = `VSCQ_S_OK;
        l = {32'h0, (sub == 32'h4) ? 16'h7FFF : 16'h0001, 16'h0101};
        i_part.kq.delete();
        for (int i = 0; i < NCMD; i++)
        begin
            sl = {32'h0, 15'h0, i[1], 7'h0, i[0], 8'h01};
            st = (i == 7) ? g : {$urandom, $urandom};
            if (i == 3)
                g = st;
            i_part.load(i, i != 7, sl, st);
            hit = (i != 7) && ((sub == 32'h4) ? sl[15:0] == l[15:0] : sl == l);
            hit = hit && ((sub != 32'h0 && sub != 32'h6) || st == g);
            if (hit && sub inside {32'h0, 32'h1, 32'h3})
                exp_k.push_back(i * 256 + 2);
            if (hit && sub inside {32'h4, 32'h5})
                exp_k.push_back(i * 256 + 4);
            if (hit && sub inside {32'h6, 32'h7})
                code = `VSCQ_S_SUCCEEDED;
        end
        if (sub > 32'h7)
            code = `VSCQ_S_REJECTED;
        slow <= sub[1:0];
        send(`VSCQ_T_TMF, sub, l, g, 32'h0);
        chk(got_code, code);
        chk(kill_at_rsp, 1'b0);
        chk(i_part.kq.size(), exp_k.size());
        foreach (exp_k[k])
            chk(i_part.kq[k], exp_k[k]);
        $display("task management subtype %0d done", sub);
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        logic [11:0] zr[5];
        logic [31:0] ty[4];
        logic [7:0]  b0[4], ex[4];
        logic [31:0] ev, sub_ev; // requested mask, the one sent with the subscription
        zr = '{`VSCQ_A_CTRL, `VSCQ_A_STAT, `VSCQ_A_MASK, `VSCQ_A_SUBS, `VSCQ_A_INFO};
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata, req_valid, rsp_ready, slow} = '0;
        {req_type, req_subtype, req_lun, req_tag, req_evmask} = '0;
        void'($urandom(32'h08DEECDF));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // reset values, a read-only place and an unmapped place
        foreach (zr[k])
        begin
            apb(1'b0, zr[k], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, `VSCQ_A_SUPP, 32'h0);
        chk(rd, `VSCQ_EVT_ALL);
        apb(1'b1, `VSCQ_A_SUBS, 32'hFFFF_FFFF);
        apb(1'b0, `VSCQ_A_SUBS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk(err, 1'b1);
        $display("register test done");
        // notify commands and unknown types: query, bad target, subscribe, unknown
        ty = '{`VSCQ_T_AN_QUERY, `VSCQ_T_AN_QUERY, `VSCQ_T_AN_SUB, 32'h3 + ($urandom % 32'h1000)};
        b0 = '{8'h01, 8'h02, 8'h01, 8'h01};
        ex = '{`VSCQ_S_OK, `VSCQ_S_BAD_TARGET, `VSCQ_S_OK, `VSCQ_S_FAILURE};
        foreach (ty[k])
        begin
            ev = $urandom;
            if (k == 2)
                sub_ev = ev;
            send(ty[k], $urandom, {$urandom, 24'h000100, b0[k]}, 64'h0, ev);
            chk(got_code, ex[k]);
            if (k != 1 && k != 3)
                chk(got_event, `VSCQ_EVT_ALL);
        end
        // subscription keeps the requested events that are supported
        apb(1'b0, `VSCQ_A_SUBS, 32'h0);
        chk(rd, sub_ev & `VSCQ_EVT_ALL);
        $display("notify test done");
        // legacy order: swapped type word
        apb(1'b1, `VSCQ_A_CTRL, 32'h1);
        send(32'h0100_0000, 32'h0, 64'h0101, 64'h0, 32'h0200_0000);
        chk(got_code, `VSCQ_S_OK);
        send(32'h0000_0001, 32'h0, 64'h0101, 64'h0, 32'h0);
        chk(got_code, `VSCQ_S_FAILURE);
        apb(1'b1, `VSCQ_A_CTRL, 32'h0);
        $display("legacy test done");
        // interrupt: masked, unmasked, cleared by read
        apb(1'b0, `VSCQ_A_STAT, 32'h0);
        apb(1'b1, `VSCQ_A_MASK, 32'h0);
        send(32'h0000_0007, 32'h0, 64'h0101, 64'h0, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `VSCQ_A_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, `VSCQ_A_STAT, 32'h0);
        chk(rd, 32'h5);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        $display("interrupt test done");
        // every task management subtype plus one unknown, with stalling kills
        for (int s = 0; s < 9; s++)
            tmf(s);
        complete_run();
    end
endmodule
`default_nettype wire
